// *** verilog/scvs_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "scvs_cfg.svh"
// Notes on behaviour
// - Six-way line voltage choice, resets to L1-N
// - Choice input true selects second bus
// - General block suppresses release and command
// - Line supervision block disables function
// - Only chosen bus supervision block counts
// - Bus change blocks function for 1000 ms
// - Five measured values feed both instances
// - Front end has no status outputs
// - Automatic and manual instances, separate thresholds
// - Cancel aborts its own instance only
// - Voltage, frequency, angle flags per instance
// - Release and in-progress flags per instance
// - Close commands go only to contacts
// - Frequency from weighted three-phase sum
// - Release after 45 ms of conditions
// - Combined command ORs both commands
module scvs_top import scvs_pkg::*; #(
    parameter int DYN_CYCLES = `SCVS_DYN_CYCLES,
    parameter int REL_CYCLES = `SCVS_REL_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Voltage choice setting
    input wire scvs_vsel_t line_voltage_choice,
    input wire logic line_voltage_choice_load,
    output var scvs_vsel_t active_voltage_choice,
    // Phasor samples
    input wire logic sample_valid,
    input wire scvs_three_t line_phasor_input,
    input wire scvs_phasor_t first_bus_phasor_input,
    input wire scvs_phasor_t second_bus_phasor_input,
    // Binary inputs
    input wire logic function_block_in,
    input wire logic line_supervision_block,
    input wire logic bus_one_supervision_block,
    input wire logic bus_two_supervision_block,
    input wire logic bus_section_choice,
    input wire logic auto_switch_request,
    input wire logic auto_cancel,
    input wire logic manual_switch_request,
    input wire logic manual_cancel,
    // Thresholds
    input wire scvs_thr_t auto_thresholds,
    input wire scvs_thr_t manual_thresholds,
    // Measured values
    output var scvs_meas_t measurements,
    // Automatic status
    output logic auto_release,
    output logic auto_in_progress,
    output logic auto_voltage_ok,
    output logic auto_frequency_ok,
    output logic auto_angle_ok,
    // Manual status
    output logic manual_release,
    output logic manual_in_progress,
    output logic manual_voltage_ok,
    output logic manual_frequency_ok,
    output logic manual_angle_ok,
    // Contact outputs
    output logic auto_close_command,
    output logic manual_close_command,
    output logic combined_close_command
);
    localparam logic [`SCVS_DCW-1:0] DYN_W = `SCVS_DCW'(DYN_CYCLES);

    // *************************
    // Phasor arithmetic
    // *************************
    function automatic scvs_wph_t ext(input scvs_phasor_t p);
        ext.re = scvs_wide_t'(p.re);
        ext.im = scvs_wide_t'(p.im);
    endfunction

    function automatic scvs_wph_t sub(input scvs_phasor_t a,
                                      input scvs_phasor_t b);
        sub.re = scvs_wide_t'(a.re) - scvs_wide_t'(b.re);
        sub.im = scvs_wide_t'(a.im) - scvs_wide_t'(b.im);
    endfunction

    function automatic logic [`SCVS_WW-1:0] absw(input scvs_wide_t v);
        absw = v[`SCVS_WW-1] ? -v : v;
    endfunction

    // Max plus half min approximation
    function automatic scvs_mag_t mag(input scvs_wph_t p);
        logic [`SCVS_WW-1:0] ax, ay;
        ax = absw(p.re);
        ay = absw(p.im);
        if (ax >= ay) begin
            mag = ax + (ay >> `SCVS_HALVE_SH);
        end else begin
            mag = ay + (ax >> `SCVS_HALVE_SH);
        end
    endfunction

    // Octant based angle, wraps modulo one turn
    function automatic scvs_ang_t bin_angle(input scvs_wph_t p);
        logic [`SCVS_WW-1:0] ax, ay;
        logic [`SCVS_WW+`SCVS_OCT_SH-1:0] nx, ny;
        logic [`SCVS_AW-1:0] a;
        ax = absw(p.re);
        ay = absw(p.im);
        nx = (`SCVS_WW+`SCVS_OCT_SH)'(ax) << `SCVS_OCT_SH;
        ny = (`SCVS_WW+`SCVS_OCT_SH)'(ay) << `SCVS_OCT_SH;
        if (ax == '0 && ay == '0) begin
            a = '0;
        end else if (ay <= ax) begin
            a = `SCVS_AW'(ny / ax);
        end else begin
            a = `SCVS_AW'(`SCVS_QUARTER) - `SCVS_AW'(nx / ay);
        end
        if (p.re < 0 && p.im >= 0) begin
            a = `SCVS_AW'(`SCVS_HALF) - a;
        end else if (p.re < 0) begin
            a = `SCVS_AW'(`SCVS_HALF) + a;
        end else if (p.im < 0) begin
            a = -a;
        end
        bin_angle = scvs_ang_t'(a);
    endfunction

    function automatic scvs_wph_t pick(input scvs_three_t t,
                                       input scvs_vsel_t s);
        case (s)
            scvs_l1n: pick = ext(t.l1);
            scvs_l2n: pick = ext(t.l2);
            scvs_l3n: pick = ext(t.l3);
            scvs_l1l2: pick = sub(t.l1, t.l2);
            scvs_l2l3: pick = sub(t.l2, t.l3);
            scvs_l3l1: pick = sub(t.l3, t.l1);
            default: pick = ext(t.l1);
        endcase
    endfunction

    // *************************
    // Input synchronisers
    // *************************
    logic [`SCVS_NSYNC-1:0] sync_a, sync_b;
    wire logic [`SCVS_NSYNC-1:0] raw_in;
    assign raw_in = {manual_cancel, manual_switch_request, auto_cancel,
                     auto_switch_request, bus_section_choice,
                     bus_two_supervision_block, bus_one_supervision_block,
                     line_supervision_block, function_block_in};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire logic func_blk, line_blk, bus1_blk, bus2_blk, bus_sel;
    assign func_blk = sync_b[`SCVS_B_BLK];
    assign line_blk = sync_b[`SCVS_B_LSUP];
    assign bus1_blk = sync_b[`SCVS_B_B1SUP];
    assign bus2_blk = sync_b[`SCVS_B_B2SUP];
    assign bus_sel = sync_b[`SCVS_B_BUS];

    // *************************
    // Blocking
    // *************************
    logic bus_q;
    logic [`SCVS_DCW-1:0] dyn_cnt;
    wire logic bus_toggle, dyn_blk, sel_bus_blk, blocked;
    assign bus_toggle = bus_sel != bus_q;
    assign dyn_blk = dyn_cnt != '0;
    assign sel_bus_blk = bus_sel ? bus2_blk : bus1_blk;
    assign blocked = func_blk || line_blk || sel_bus_blk ||
        dyn_blk;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_q <= 1'b0;
            dyn_cnt <= '0;
        end else begin
            bus_q <= bus_sel;
            if (bus_toggle) begin
                dyn_cnt <= DYN_W;
            end else if (dyn_blk) begin
                dyn_cnt <= dyn_cnt - 1'b1;
            end
        end
    end

    // *************************
    // Voltage selection and values
    // *************************
    scvs_ang_t prev_w, prev_bus;
    wire scvs_wph_t line_ph, bus_ph, wsum;
    wire scvs_mag_t line_mag, bus_mag;
    wire scvs_ang_t ang_line, ang_bus, ang_w;
    assign line_ph = pick(line_phasor_input, active_voltage_choice);
    assign bus_ph = bus_sel ? ext(second_bus_phasor_input) :
        ext(first_bus_phasor_input);
    assign wsum.re = scvs_wide_t'(line_phasor_input.l1.re) -
        (scvs_wide_t'(line_phasor_input.l2.re) >>> `SCVS_HALVE_SH) -
        (scvs_wide_t'(line_phasor_input.l3.re) >>> `SCVS_HALVE_SH);
    assign wsum.im = scvs_wide_t'(line_phasor_input.l1.im) -
        (scvs_wide_t'(line_phasor_input.l2.im) >>> `SCVS_HALVE_SH) -
        (scvs_wide_t'(line_phasor_input.l3.im) >>> `SCVS_HALVE_SH);
    assign line_mag = mag(line_ph);
    assign bus_mag = mag(bus_ph);
    assign ang_line = bin_angle(line_ph);
    assign ang_bus = bin_angle(bus_ph);
    assign ang_w = bin_angle(wsum);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            active_voltage_choice <= scvs_l1n;
        end else if (line_voltage_choice_load) begin
            active_voltage_choice <= line_voltage_choice;
        end
    end

    // Values only, no flags leave the front end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            measurements <= '0;
            prev_w <= '0;
            prev_bus <= '0;
        end else if (sample_valid) begin
            prev_w <= ang_w;
            prev_bus <= ang_bus;
            measurements.u_line <= line_mag;
            measurements.u_bus <= bus_mag;
            measurements.u_diff <= scvs_udiff_t'({1'b0, line_mag}) -
                scvs_udiff_t'({1'b0, bus_mag});
            measurements.angle_difference <= ang_line - ang_bus;
            measurements.f_diff <= (ang_w - prev_w) -
                (ang_bus - prev_bus);
        end
    end

    // *************************
    // Evaluation instances
    // *************************
    scvs_flags_t auto_flags, man_flags;

    scvs_eval #(
        .REL_CYCLES(REL_CYCLES),
        .PULSE_CYCLES(`SCVS_PULSE_CYCLES)
    ) u_auto (
        .ref_clk(ref_clk),
        .srst(srst),
        .meas(measurements),
        .thr(auto_thresholds),
        .blocked(blocked),
        .switch_request(sync_b[`SCVS_B_AREQ]),
        .cancel(sync_b[`SCVS_B_ACAN]),
        .flags(auto_flags),
        .close_command(auto_close_command)
    );

    scvs_eval #(
        .REL_CYCLES(REL_CYCLES),
        .PULSE_CYCLES(`SCVS_PULSE_CYCLES)
    ) u_manual (
        .ref_clk(ref_clk),
        .srst(srst),
        .meas(measurements),
        .thr(manual_thresholds),
        .blocked(blocked),
        .switch_request(sync_b[`SCVS_B_MREQ]),
        .cancel(sync_b[`SCVS_B_MCAN]),
        .flags(man_flags),
        .close_command(manual_close_command)
    );

    assign auto_release = auto_flags.rel_on;
    assign auto_in_progress = auto_flags.in_progress;
    assign auto_voltage_ok = auto_flags.voltage_ok;
    assign auto_frequency_ok = auto_flags.frequency_ok;
    assign auto_angle_ok = auto_flags.angle_ok;
    assign manual_release = man_flags.rel_on;
    assign manual_in_progress = man_flags.in_progress;
    assign manual_voltage_ok = man_flags.voltage_ok;
    assign manual_frequency_ok = man_flags.frequency_ok;
    assign manual_angle_ok = man_flags.angle_ok;

    // Contact-only command, kept off the status group
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            combined_close_command <= 1'b0;
        end else begin
            combined_close_command <= auto_close_command ||
                manual_close_command;
        end
    end

    // *************************
    // Checks
    // *************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_bus_change;
        $changed(bus_sel);
    endsequence

    a_dyn_hold:
    assert property (s_bus_change |=> dyn_blk [*8])
        else $error("bus change did not hold block");
    a_dyn_restart:
    assert property (s_bus_change |=> dyn_cnt == DYN_W)
        else $error("block timer not restarted");
    a_block_gate:
    assert property (func_blk |=> !auto_close_command &&
        !manual_close_command && !auto_release && !manual_release)
        else $error("output while blocked");
    a_line_sup:
    assert property (line_blk |=> !auto_release && !manual_release)
        else $error("release during line supervision block");
    a_bus_sup:
    assert property (sel_bus_blk |=> !auto_release && !manual_release)
        else $error("release during bus supervision block");
    a_bus_route:
    assert property (sample_valid && bus_sel |=>
        measurements.u_bus == mag(ext($past(second_bus_phasor_input))))
        else $error("wrong bus section routed");
    a_combined_or:
    assert property (combined_close_command ==
        $past(auto_close_command || manual_close_command))
        else $error("combined command mismatch");
    a_choice_reset:
    assert property ($past(srst) |-> active_voltage_choice == scvs_l1n)
        else $error("voltage choice not reset");
endmodule
`default_nettype wire

// *** verilog/scvs_cfg.svh ***
`ifndef SCVS_CFG_SVH
`define SCVS_CFG_SVH

// Widths
`define SCVS_CW 16
`define SCVS_WW 18
`define SCVS_MW 18
`define SCVS_AW 9
`define SCVS_DCW 26
`define SCVS_RCW 22
`define SCVS_PCW 5

// Timing
`define SCVS_CLK_HZ 50000000
`define SCVS_MS_PER_S 1000
`define SCVS_DYN_MS 1000
`define SCVS_REL_MS 45
`define SCVS_DYN_CYCLES (`SCVS_DYN_MS * (`SCVS_CLK_HZ / `SCVS_MS_PER_S))
`define SCVS_REL_CYCLES (`SCVS_REL_MS * (`SCVS_CLK_HZ / `SCVS_MS_PER_S))
`define SCVS_PULSE_CYCLES 16

// Binary angle, 512 steps a turn
`define SCVS_OCT_SH 6
`define SCVS_QUARTER 128
`define SCVS_HALF 256
`define SCVS_HALVE_SH 1

// Synchroniser bit positions
`define SCVS_NSYNC 9
`define SCVS_B_BLK 0
`define SCVS_B_LSUP 1
`define SCVS_B_B1SUP 2
`define SCVS_B_B2SUP 3
`define SCVS_B_BUS 4
`define SCVS_B_AREQ 5
`define SCVS_B_ACAN 6
`define SCVS_B_MREQ 7
`define SCVS_B_MCAN 8

`endif

// *** verilog/scvs_pkg.sv ***
`include "scvs_cfg.svh"
package scvs_pkg;
    typedef enum logic [2:0] {
        scvs_l1n, scvs_l2n, scvs_l3n, scvs_l1l2, scvs_l2l3, scvs_l3l1
    } scvs_vsel_t;
    typedef logic signed [`SCVS_CW-1:0] scvs_comp_t;
    typedef logic signed [`SCVS_WW-1:0] scvs_wide_t;
    typedef struct packed {scvs_comp_t re; scvs_comp_t im;} scvs_phasor_t;
    typedef struct packed {scvs_wide_t re; scvs_wide_t im;} scvs_wph_t;
    typedef struct packed {
        scvs_phasor_t l1; scvs_phasor_t l2; scvs_phasor_t l3;
    } scvs_three_t;
    typedef logic [`SCVS_MW-1:0] scvs_mag_t;
    typedef logic signed [`SCVS_MW:0] scvs_udiff_t;
    typedef logic signed [`SCVS_AW-1:0] scvs_ang_t;
    typedef logic [`SCVS_AW-1:0] scvs_angmag_t;
    typedef struct packed {
        scvs_udiff_t u_diff;
        scvs_ang_t f_diff;
        scvs_ang_t angle_difference;
        scvs_mag_t u_line;
        scvs_mag_t u_bus;
    } scvs_meas_t;
    typedef struct packed {
        scvs_mag_t u_diff_max;
        scvs_angmag_t f_diff_max;
        scvs_angmag_t angle_max;
    } scvs_thr_t;
    typedef struct packed {
        logic rel_on;
        logic in_progress;
        logic voltage_ok;
        logic frequency_ok;
        logic angle_ok;
    } scvs_flags_t;
endpackage

// *** verilog/scvs_eval.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "scvs_cfg.svh"
module scvs_eval import scvs_pkg::*; #(
    parameter int REL_CYCLES = `SCVS_REL_CYCLES,
    parameter int PULSE_CYCLES = `SCVS_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Front end values and settings
    input wire scvs_meas_t meas,
    input wire scvs_thr_t thr,
    // Control
    input wire logic blocked,
    input wire logic switch_request,
    input wire logic cancel,
    // Status
    output var scvs_flags_t flags,
    output logic close_command
);
    typedef enum logic [1:0] {scvs_idle, scvs_wait, scvs_close} scvs_state_t;
    localparam logic [`SCVS_RCW-1:0] REL_W = `SCVS_RCW'(REL_CYCLES);
    localparam logic [`SCVS_PCW-1:0] PULSE_W = `SCVS_PCW'(PULSE_CYCLES - 1);

    scvs_state_t state, next_state;
    logic [`SCVS_RCW-1:0] hold, next_hold;
    logic [`SCVS_PCW-1:0] pulse;
    logic req_q;
    wire logic [`SCVS_MW:0] u_abs;
    wire scvs_angmag_t f_abs;
    wire scvs_angmag_t a_abs;
    wire logic cond_v, cond_f, cond_a, all_ok, start, next_rel;

    // *************************
    // Condition checks
    // *************************
    assign u_abs = meas.u_diff[`SCVS_MW] ? -meas.u_diff : meas.u_diff;
    assign f_abs = meas.f_diff[`SCVS_AW-1] ? -meas.f_diff : meas.f_diff;
    assign a_abs = meas.angle_difference[`SCVS_AW-1] ?
        -meas.angle_difference : meas.angle_difference;
    assign cond_v = u_abs <= {1'b0, thr.u_diff_max};
    assign cond_f = f_abs <= thr.f_diff_max;
    assign cond_a = a_abs <= thr.angle_max;
    assign all_ok = cond_v && cond_f && cond_a && !blocked;
    // Continuous-hold timer
    assign next_hold = !all_ok ? '0 :
        (hold == REL_W) ? hold : hold + 1'b1;
    assign next_rel = all_ok && next_hold == REL_W;
    assign start = switch_request && !req_q && !cancel && !blocked;

    // *************************
    // Procedure sequencing
    // *************************
    always_comb begin
        next_state = state;
        case (state)
            scvs_idle: begin
                if (start) begin
                    next_state = scvs_wait;
                end
            end
            scvs_wait: begin
                if (cancel || blocked) begin
                    next_state = scvs_idle;
                end else if (flags.rel_on && all_ok) begin
                    next_state = scvs_close;
                end
            end
            scvs_close: begin
                if (cancel || blocked || pulse == PULSE_W) begin
                    next_state = scvs_idle;
                end
            end
            default: next_state = scvs_idle;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= scvs_idle;
            hold <= '0;
            pulse <= '0;
            req_q <= 1'b0;
            flags <= '0;
            close_command <= 1'b0;
        end else begin
            state <= next_state;
            hold <= next_hold;
            pulse <= (state == scvs_close) ? pulse + 1'b1 : '0;
            req_q <= switch_request;
            flags.rel_on <= next_rel;
            flags.in_progress <= next_state != scvs_idle;
            flags.voltage_ok <= cond_v && !blocked;
            flags.frequency_ok <= cond_f && !blocked;
            flags.angle_ok <= cond_a && !blocked;
            close_command <= next_state == scvs_close;
        end
    end

    // *************************
    // Checks
    // *************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_start;
        state == scvs_idle && start;
    endsequence
    sequence s_abort;
        state != scvs_idle && cancel;
    endsequence

    a_start_in_progress:
    assert property (s_start |=> flags.in_progress && !close_command)
        else $error("start did not raise in progress");
    a_cancel_abort:
    assert property (s_abort |=> !flags.in_progress && !close_command)
        else $error("cancel did not abort procedure");
    a_release_hold:
    assert property (flags.rel_on |-> hold == REL_W && $past(all_ok))
        else $error("release before full hold time");
    a_close_after_rel:
    assert property ($rose(close_command) |-> $past(flags.rel_on))
        else $error("close without release");
    a_voltage_flag:
    assert property (flags.voltage_ok |-> $past(cond_v) && !$past(blocked))
        else $error("voltage flag without condition");
endmodule
`default_nettype wire

// *** test/scvs_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Reclosing logic, operator and breaker coil
// ****************************************
module scvs_partner (
    // Clock
    input wire logic ref_clk,
    // Commands from bench: bit 0 auto, bit 1 manual
    input wire logic [1:0] go,
    input wire logic [1:0] stop,
    // Requests and cancels
    output logic auto_switch_request,
    output logic manual_switch_request,
    output logic auto_cancel,
    output logic manual_cancel,
    // Close coils: auto, manual, combined
    input wire logic [2:0] coil,
    output int plen [3],
    output int pcnt [3]
);
    int run [3];
    logic [1:0] go_q, stop_q;

    initial begin
        auto_switch_request = 1'b0;
        manual_switch_request = 1'b0;
        auto_cancel = 1'b0;
        manual_cancel = 1'b0;
        run = '{0, 0, 0};
        plen = '{0, 0, 0};
        pcnt = '{0, 0, 0};
    end
    // Each request and cancel on its own line
    always @(posedge ref_clk) begin
        go_q = go;
        stop_q = stop;
        #2;
        auto_switch_request = go_q[0];
        manual_switch_request = go_q[1];
        auto_cancel = stop_q[0];
        manual_cancel = stop_q[1];
    end
    // Measures each close pulse seen by the coil
    always @(posedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (coil[i] === 1'b1) begin
                run[i] <= run[i] + 1;
            end else if (run[i] != 0) begin
                plen[i] <= run[i];
                pcnt[i] <= pcnt[i] + 1;
                run[i] <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/sync_check_voltage_select_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
        err_count++; \
        $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module sync_check_voltage_select_tb import scvs_pkg::*;;
    localparam int DYN = 40;
    localparam int REL = 10;
    typedef struct packed {
        scvs_vsel_t v; logic b; logic [17:0] ul; logic [17:0] ub;
    } scvs_tb_row_t;
    scvs_tb_row_t rows [6] = '{
        '{scvs_l1n, 1'b0, 18'h003e8, 18'h00320},
        '{scvs_l2n, 1'b1, 18'h0012c, 18'h00190},
        '{scvs_l3n, 1'b0, 18'h000c8, 18'h00320},
        '{scvs_l1l2, 1'b1, 18'h002bc, 18'h00190},
        '{scvs_l2l3, 1'b0, 18'h001f4, 18'h00320},
        '{scvs_l3l1, 1'b1, 18'h004b0, 18'h00190}};
    logic ref_clk, srst, ld, sv, fblk, lsup, b1sup, b2sup, bsel;
    logic areq, acan, mreq, mcan, acl, mcl, ccl;
    logic [4:0] af, mf;
    logic [1:0] go, stop;
    logic signed [18:0] ud;
    scvs_vsel_t vch, act;
    scvs_three_t lph;
    scvs_phasor_t b1ph, b2ph;
    scvs_thr_t athr, mthr;
    scvs_meas_t meas;
    int plen [3];
    int pcnt [3];
    int err_count = 0;
    int total_checks = 0;
    int d, n, prev;

    scvs_top #(.DYN_CYCLES(DYN), .REL_CYCLES(REL)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .line_voltage_choice(vch),
        .line_voltage_choice_load(ld), .active_voltage_choice(act),
        .sample_valid(sv), .line_phasor_input(lph),
        .first_bus_phasor_input(b1ph), .second_bus_phasor_input(b2ph),
        .function_block_in(fblk), .line_supervision_block(lsup),
        .bus_one_supervision_block(b1sup),
        .bus_two_supervision_block(b2sup), .bus_section_choice(bsel),
        .auto_switch_request(areq), .auto_cancel(acan),
        .manual_switch_request(mreq), .manual_cancel(mcan),
        .auto_thresholds(athr), .manual_thresholds(mthr),
        .measurements(meas), .auto_release(af[4]),
        .auto_in_progress(af[3]), .auto_voltage_ok(af[2]),
        .auto_frequency_ok(af[1]), .auto_angle_ok(af[0]),
        .manual_release(mf[4]), .manual_in_progress(mf[3]),
        .manual_voltage_ok(mf[2]), .manual_frequency_ok(mf[1]),
        .manual_angle_ok(mf[0]), .auto_close_command(acl),
        .manual_close_command(mcl), .combined_close_command(ccl));
    scvs_partner i_partner (
        .ref_clk(ref_clk), .go(go), .stop(stop),
        .auto_switch_request(areq), .manual_switch_request(mreq),
        .auto_cancel(acan), .manual_cancel(mcan),
        .coil({ccl, mcl, acl}), .plen(plen), .pcnt(pcnt));

    // ****************************************
    // Clock, helpers and watchdog
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", total_checks,
                 err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wait_rel();
        n = 0;
        while (af[4] !== 1'b1) begin
            tick(1);
            n++;
            if (n > 300) begin
                err_count++;
                $display("ERROR release expected 1 seen %0h", af[4]);
                conclude();
            end
        end
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("ERROR watchdog expected 0 seen 1");
        conclude();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        srst = 1'b1;
        {ld, fblk, lsup, b1sup, b2sup, bsel} = 6'h00;
        sv = 1'b1;
        go = 2'b00;
        stop = 2'b00;
        vch = scvs_l1n;
        lph = {16'h03e8, 16'h0000, 16'h012c, 16'h0000, 16'hff38, 16'h0000};
        b1ph = {16'h0320, 16'h0000};
        b2ph = {16'h0190, 16'h0000};
        athr = {18'h0012c, 9'h0ff, 9'h0ff};
        mthr = {18'h00258, 9'h0ff, 9'h0ff};
        tick(8);
        srst = 1'b0;
        `CHK("reset choice", scvs_l1n, act)
        `CHK("reset flags", 10'h000, {af, mf})
        `CHK("reset close", 3'h0, {ccl, mcl, acl})
        foreach (rows[i]) begin
            vch = rows[i].v;
            bsel = rows[i].b;
            ld = 1'b1;
            tick(1);
            ld = 1'b0;
            tick(DYN + 8);
            d = rows[i].ul - rows[i].ub;
            if (d < 0) d = -d;
            ud = meas.u_diff[18] ? -meas.u_diff : meas.u_diff;
            `CHK("choice", rows[i].v, act)
            `CHK("u_line", rows[i].ul, meas.u_line)
            `CHK("u_bus", rows[i].ub, meas.u_bus)
            `CHK("u_diff", 19'(d), ud)
            `CHK("f_diff", 9'h000, meas.f_diff)
            `CHK("auto u ok", d <= 300, af[2])
            `CHK("man u ok", d <= 600, mf[2])
        end
        $display("Test rows done");
        vch = scvs_l1n;
        ld = 1'b1;
        b1ph = {16'h03e8, 16'h0000};
        b2ph = b1ph;
        bsel = 1'b0;
        tick(1);
        ld = 1'b0;
        tick(DYN + 8);
        bsel = 1'b1;
        tick(4);
        `CHK("blocked release", 1'b0, af[4])
        wait_rel();
        `CHK("release delay", 1'b1, n >= DYN + REL - 1)
        `CHK("release bound", 1'b1, n <= DYN + REL + 5)
        `CHK("angle", 9'h000, meas.angle_difference)
        `CHK("ok flags", 3'h7, af[2:0])
        `CHK("man flags", 5'h17, mf)
        bsel = 1'b0;
        tick(DYN - 10);
        bsel = 1'b1;
        tick(DYN - 10);
        `CHK("retoggle", 1'b0, af[4])
        wait_rel();
        $display("Test bus change done");
        stop = 2'b10;
        go = 2'b11;
        tick(8);
        `CHK("auto busy", 1'b1, af[3])
        `CHK("man busy", 1'b0, mf[3])
        tick(25);
        `CHK("auto pulses", 1, pcnt[0])
        `CHK("auto width", 16, plen[0])
        `CHK("man pulses", 0, pcnt[1])
        `CHK("or width", 16, plen[2])
        go = 2'b00;
        stop = 2'b00;
        tick(3);
        go = 2'b10;
        tick(30);
        `CHK("man after", 1, pcnt[1])
        `CHK("or pulses", 2, pcnt[2])
        go = 2'b00;
        $display("Test close done");
        for (int k = 0; k < 4; k++) begin
            prev = pcnt[0];
            {fblk, lsup, b1sup, b2sup} = 4'h8 >> k;
            tick(4);
            `CHK("src release", k == 2, af[4])
            go[0] = 1'b1;
            tick(25);
            `CHK("src close", prev + (k == 2), pcnt[0])
            go[0] = 1'b0;
            {fblk, lsup, b1sup, b2sup} = 4'h0;
            tick(2);
            wait_rel();
        end
        $display("Test blocking done");
        sv = 1'b0;
        b2ph = {16'h0190, 16'h0000};
        tick(3);
        `CHK("held u_bus", 18'h003e8, meas.u_bus)
        sv = 1'b1;
        tick(1);
        `CHK("new u_bus", 18'h00190, meas.u_bus)
        go = 2'b01;
        tick(6);
        `CHK("wait busy", 1'b1, af[3])
        stop = 2'b01;
        tick(5);
        `CHK("cancel abort", 1'b0, af[3])
        go = 2'b00;
        stop = 2'b00;
        $display("Test cancel done");
        vch = scvs_l3l1;
        ld = 1'b1;
        tick(1);
        ld = 1'b0;
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        `CHK("rereset choice", scvs_l1n, act)
        `CHK("rereset flags", 5'h00, af)
        $display("Test reset done");
        conclude();
    end
endmodule
`default_nettype wire
